//--- verilog/lpib_top.sv
`default_nettype none
module lpib_top (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic plat_rst_n,
	input wire logic cyc_req,
	input wire logic cyc_io,
	input wire logic cyc_wr,
	input wire logic [31:0] cyc_addr,
	input wire logic [7:0] cyc_wdata,
	output logic cyc_claim,
	output logic cyc_wait,
	output logic cyc_done,
	output logic [7:0] cyc_rdata,
	output logic isa_req,
	output logic isa_io,
	output logic isa_wr,
	output logic [23:0] isa_addr,
	output logic [7:0] isa_wdata,
	input wire logic isa_ack,
	input wire logic [7:0] isa_rdata,
	output logic tmr_we,
	output logic tmr_re,
	output logic [1:0] tmr_addr,
	output logic [7:0] tmr_wdata,
	input wire logic [7:0] tmr_rdata,
	input wire logic [2:0] tmr_evt,
	input wire logic dio_evt,
	input wire logic aux_evt,
	input wire logic wdt_evt,
	input wire logic [15:0] isa_irq_pin,
	input wire logic [3:0] uart_irq_pin,
	input wire logic exp_irq_pin,
	input wire logic therm_pin,
	input wire logic batt_low_pin,
	output logic [15:0] irq_active,
	output logic [15:0] irq_level,
	output logic [7:0] aux_gpio_out
);
	// Level index from a three-bit select: 3,4,5,6,7,9,10,11
	function automatic logic [15:0] lvl_vec(input logic en, input logic [2:0] sel);
		logic [3:0] n;
		n = 4'h0;
		unique case (sel)
			3'h0: n = 4'h3;
			3'h1: n = 4'h4;
			3'h2: n = 4'h5;
			3'h3: n = 4'h6;
			3'h4: n = 4'h7;
			3'h5: n = 4'h9;
			3'h6: n = 4'ha;
			3'h7: n = 4'hb;
		endcase
		lvl_vec = en ? (16'h0001 << n) : 16'h0000;
	endfunction

	// Expansion serial interrupt: only levels 5, 7, 10, 11
	function automatic logic [15:0] exp_vec(input logic en, input logic [1:0] sel);
		logic [3:0] n;
		n = 4'h0;
		unique case (sel)
			2'h0: n = 4'h5;
			2'h1: n = 4'h7;
			2'h2: n = 4'ha;
			2'h3: n = 4'hb;
		endcase
		exp_vec = en ? (16'h0001 << n) : 16'h0000;
	endfunction

	// Synchronised pins
	logic [lpib_pkg::SYNC_W-1:0] pin_s;
	lpib_sync #(.W(lpib_pkg::SYNC_W)) u_sync (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.d({batt_low_pin, therm_pin, exp_irq_pin, uart_irq_pin, isa_irq_pin, plat_rst_n}),
		.q(pin_s)
	);
	wire plat_n_s = pin_s[0];
	wire [15:0] isa_irq_s = pin_s[16:1];
	wire [3:0] uart_irq_s = pin_s[20:17];
	wire exp_irq_s = pin_s[21];
	wire [1:0] env_evt_s = pin_s[23:22];

	// Registers
	logic keep_r;
	logic [3:0] tmr_cfg_r, dio_cfg_r, aux_cfg_r, wdt_cfg_r, env_cfg_r;
	logic [2:0] tmr_mask_r, tmr_stat_r;
	logic dio_mask_r, dio_stat_r, aux_stat_r, wdt_stat_r, env_rep_r;
	logic [1:0] env_stat_r, env_mask_r;
	logic [1:0] exp_sel_r;
	logic exp_en_r;
	logic [15:0] isa_en_r;
	logic [3:0] uart_cfg_r [4];
	logic [7:0] aux_out_r;

	// Resets: platform from pin, sleep-aware follows platform unless kept
	wire plat_clr = !plat_n_s;
	// Platform domain reset: power-on or synchronised platform pin
	wire plat_rstn = rstn && plat_n_s;
	wire sleep_clr = plat_clr && !keep_r;

	// Cycle decode
	wire [15:0] io_a = cyc_addr[15:0];
	wire in_win = cyc_io && io_a >= lpib_pkg::WIN_LO && io_a <= lpib_pkg::WIN_HI;
	wire [6:0] off = 7'(io_a - lpib_pkg::WIN_LO);
	wire sio_hit = (io_a >= lpib_pkg::SIO_IDX_LO && io_a <= lpib_pkg::SIO_IDX_HI)
		|| (io_a >= lpib_pkg::SIO_RT_LO && io_a <= lpib_pkg::SIO_RT_HI);
	wire io_fwd = cyc_io && !in_win && !sio_hit;
	wire mem_fwd = !cyc_io && cyc_addr < lpib_pkg::MEM_LIMIT;
	wire fwd_busy;
	wire fwd_go = cyc_req && (io_fwd || mem_fwd) && !fwd_busy;
	wire own_go = cyc_req && in_win;
	wire reg_we = own_go && cyc_wr;
	wire reg_re = own_go && !cyc_wr;
	wire tmr_hit = off >= lpib_pkg::OFF_TMR_BASE && off < lpib_pkg::OFF_UART_BASE;
	wire uart_hit = off >= lpib_pkg::OFF_UART_BASE;
	wire [1:0] uart_idx = off[1:0];
	wire uart_cfg_hit = uart_hit && off[3:2] == 2'h0;

	// Write-one-clear strobes on status bytes and on the watchdog configuration byte
	function automatic logic w1c(input logic [6:0] o, input logic [6:0] r);
		w1c = o == r;
	endfunction
	wire [7:0] wd = cyc_wdata;
	wire [2:0] tmr_clr = (reg_we && w1c(off, lpib_pkg::OFF_TMR_STAT)) ? wd[2:0] : 3'h0;
	wire dio_clr = reg_we && w1c(off, lpib_pkg::OFF_DIO_STAT) && wd[0];
	wire aux_clr = reg_we && w1c(off, lpib_pkg::OFF_AUX_STAT) && wd[0];
	wire wdt_clr = reg_we && w1c(off, lpib_pkg::OFF_WDT_CFG) && wd[0];
	wire [1:0] env_clr = (reg_we && w1c(off, lpib_pkg::OFF_ENV_STAT)) ? wd[1:0] : 2'h0;
	wire env_test = reg_we && off == lpib_pkg::OFF_ENV_CFG && wd[lpib_pkg::ENV_TEST];
	wire [1:0] env_set = env_evt_s | {2{env_test}};
	wire env_rep_rd = reg_re && off == lpib_pkg::OFF_ENV_STAT;

	// Timer sub-block pass-through at fixed base
	assign tmr_we = reg_we && tmr_hit;
	assign tmr_re = reg_re && tmr_hit;
	assign tmr_addr = off[1:0];
	assign tmr_wdata = cyc_wdata;

	// Power-on domain: power keep bit
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			keep_r <= 1'b0;
		end else if (reg_we && off == lpib_pkg::OFF_MISC1) begin
			keep_r <= wd[lpib_pkg::MISC1_KEEP];
		end
	end

	// Sleep-aware domain: aux GPIO outputs
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			aux_out_r <= lpib_pkg::RST_BYTE;
		end else if (sleep_clr) begin
			aux_out_r <= lpib_pkg::RST_BYTE;
		end else if (reg_we && off == lpib_pkg::OFF_AUX_OUT) begin
			aux_out_r <= wd;
		end
	end
	assign aux_gpio_out = aux_out_r;

	// Platform domain configuration registers
	always_ff @(posedge clk_sys or negedge plat_rstn) begin
		if (!plat_rstn) begin
			tmr_cfg_r <= lpib_pkg::RST_CFG;
			dio_cfg_r <= lpib_pkg::RST_CFG;
			aux_cfg_r <= lpib_pkg::RST_CFG;
			wdt_cfg_r <= lpib_pkg::RST_CFG;
			env_cfg_r <= lpib_pkg::RST_CFG;
			tmr_mask_r <= '0;
			dio_mask_r <= 1'b0;
			env_mask_r <= '0;
			exp_sel_r <= '0;
			exp_en_r <= 1'b0;
			isa_en_r <= lpib_pkg::RST_ISA_EN;
		end else if (reg_we) begin
			unique case (off)
				lpib_pkg::OFF_TMR_CFG: {tmr_cfg_r, tmr_mask_r} <= {wd[7:4], wd[2:0]};
				lpib_pkg::OFF_DIO_CFG: dio_cfg_r <= wd[7:4];
				lpib_pkg::OFF_DIO_MASK: dio_mask_r <= wd[0];
				lpib_pkg::OFF_AUX_CFG: aux_cfg_r <= wd[7:4];
				lpib_pkg::OFF_WDT_CFG: wdt_cfg_r <= wd[7:4];
				lpib_pkg::OFF_ENV_CFG: {env_cfg_r, env_mask_r} <= {wd[7:4], wd[1:0]};
				lpib_pkg::OFF_EXP_CFG: begin
					exp_sel_r <= wd[lpib_pkg::EXP_SEL +: 2];
					exp_en_r <= wd[lpib_pkg::EXP_EN];
				end
				lpib_pkg::OFF_ISA_EN_LO: isa_en_r[7:0] <= wd & lpib_pkg::ISA_LINES[7:0];
				lpib_pkg::OFF_ISA_EN_HI: isa_en_r[15:8] <= wd & lpib_pkg::ISA_LINES[15:8];
				default: ;
			endcase
		end
	end

	// UART level selects, one per port
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_uart
			always_ff @(posedge clk_sys or negedge plat_rstn) begin
				if (!plat_rstn) begin
					uart_cfg_r[gi] <= lpib_pkg::RST_CFG;
				end else if (reg_we && uart_cfg_hit && uart_idx == 2'(gi)) begin
					uart_cfg_r[gi] <= wd[7:4];
				end
			end
		end
	endgenerate

	// Sticky status, set wins over write-one clear
	always_ff @(posedge clk_sys or negedge plat_rstn) begin
		if (!plat_rstn) begin
			tmr_stat_r <= '0;
			dio_stat_r <= 1'b0;
			aux_stat_r <= 1'b0;
			wdt_stat_r <= 1'b0;
			env_stat_r <= '0;
		end else begin
			tmr_stat_r <= tmr_evt | (tmr_stat_r & ~tmr_clr);
			dio_stat_r <= dio_evt | (dio_stat_r & !dio_clr);
			aux_stat_r <= aux_evt | (aux_stat_r & !aux_clr);
			wdt_stat_r <= wdt_evt | (wdt_stat_r & !wdt_clr);
			env_stat_r <= env_set | (env_stat_r & ~env_clr);
		end
	end

	// Repeat flag: event on an already set bit, cleared by reading
	always_ff @(posedge clk_sys or negedge plat_rstn) begin
		if (!plat_rstn) begin
			env_rep_r <= 1'b0;
		end else begin
			env_rep_r <= (|(env_set & env_stat_r)) || (env_rep_r && !env_rep_rd);
		end
	end

	// Source requests and their levels
	wire tmr_on = |(tmr_stat_r & tmr_mask_r);
	wire dio_on = dio_stat_r && dio_mask_r;
	wire env_on = |(env_stat_r & env_mask_r);
	wire [15:0] tmr_v = lvl_vec(tmr_cfg_r[3], tmr_cfg_r[2:0]);
	wire [15:0] dio_v = lvl_vec(dio_cfg_r[3], dio_cfg_r[2:0]);
	wire [15:0] aux_v = lvl_vec(aux_cfg_r[3], aux_cfg_r[2:0]);
	wire [15:0] wdt_v = lvl_vec(wdt_cfg_r[3], wdt_cfg_r[2:0]);
	wire [15:0] env_v = lvl_vec(env_cfg_r[3], env_cfg_r[2:0]);
	wire [15:0] exp_v = exp_vec(exp_en_r, exp_sel_r);
	logic [15:0] uart_v [4];
	logic [15:0] uart_act [4];
	generate
		for (gi = 0; gi < 4; gi++) begin : g_uv
			assign uart_v[gi] = lvl_vec(uart_cfg_r[gi][3], uart_cfg_r[gi][2:0]);
			assign uart_act[gi] = uart_irq_s[gi] ? uart_v[gi] : 16'h0000;
		end
	endgenerate
	wire [15:0] uart_en_all = uart_v[0] | uart_v[1] | uart_v[2] | uart_v[3];
	wire [15:0] uart_req_all = uart_act[0] | uart_act[1] | uart_act[2] | uart_act[3];

	// Shared levels OR together; slots active while any user enabled
	wire [15:0] act_nxt = tmr_v | dio_v | aux_v | wdt_v | env_v | exp_v | uart_en_all
		| isa_en_r;
	wire [15:0] lvl_nxt = ({16{tmr_on}} & tmr_v) | ({16{dio_on}} & dio_v)
		| ({16{aux_stat_r}} & aux_v) | ({16{wdt_stat_r}} & wdt_v)
		| ({16{env_on}} & env_v) | ({16{exp_irq_s}} & exp_v) | uart_req_all
		| (isa_irq_s & isa_en_r);

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			irq_active <= '0;
			irq_level <= '0;
		end else begin
			irq_active <= act_nxt;
			irq_level <= lvl_nxt & act_nxt;
		end
	end

	// Read selection; reserved offsets read zero
	logic [7:0] rd_val;
	always_comb begin
		rd_val = 8'h00;
		if (tmr_hit) begin
			rd_val = tmr_rdata;
		end else if (uart_cfg_hit) begin
			rd_val = {uart_cfg_r[uart_idx], 4'h0};
		end else if (!uart_hit) begin
			unique case (off)
				lpib_pkg::OFF_TMR_CFG: rd_val = {tmr_cfg_r, 1'b0, tmr_mask_r};
				lpib_pkg::OFF_TMR_STAT: rd_val = {5'h00, tmr_stat_r};
				lpib_pkg::OFF_EXP_CFG: rd_val = {exp_sel_r, 2'h0, exp_en_r, 1'b0,
					exp_irq_s, 1'b0};
				lpib_pkg::OFF_MISC1: rd_val = {6'h00, keep_r, 1'b0};
				lpib_pkg::OFF_DIO_MASK: rd_val = {7'h00, dio_mask_r};
				lpib_pkg::OFF_DIO_STAT: rd_val = {7'h00, dio_stat_r};
				lpib_pkg::OFF_DIO_CFG: rd_val = {dio_cfg_r, 4'h0};
				lpib_pkg::OFF_AUX_OUT: rd_val = aux_out_r;
				lpib_pkg::OFF_AUX_STAT: rd_val = {7'h00, aux_stat_r};
				lpib_pkg::OFF_WDT_CFG: rd_val = {wdt_cfg_r, 3'h0, wdt_stat_r};
				lpib_pkg::OFF_AUX_CFG: rd_val = {aux_cfg_r, 4'h0};
				lpib_pkg::OFF_ENV_CFG: rd_val = {env_cfg_r, 2'h0, env_mask_r};
				lpib_pkg::OFF_ENV_STAT: rd_val = {env_rep_r, 5'h00, env_stat_r};
				lpib_pkg::OFF_ISA_EN_LO: rd_val = isa_en_r[7:0];
				lpib_pkg::OFF_ISA_EN_HI: rd_val = isa_en_r[15:8];
				default: rd_val = 8'h00;
			endcase
		end
	end

	// Forwarding engine toward the expansion bus
	wire fwd_done;
	wire [7:0] fwd_rdata;
	lpib_fwd u_fwd (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.start(fwd_go),
		.io(cyc_io),
		.wr(cyc_wr),
		.addr(cyc_addr[23:0]),
		.wdata(cyc_wdata),
		.busy(fwd_busy),
		.done(fwd_done),
		.rdata(fwd_rdata),
		.isa_req(isa_req),
		.isa_io(isa_io),
		.isa_wr(isa_wr),
		.isa_addr(isa_addr),
		.isa_wdata(isa_wdata),
		.isa_ack(isa_ack),
		.isa_rdata(isa_rdata)
	);

	// Cycle answer: claim now, wait while forwarding, data with done
	assign cyc_claim = own_go || fwd_go;
	assign cyc_wait = fwd_busy;
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			cyc_done <= 1'b0;
			cyc_rdata <= '0;
		end else begin
			cyc_done <= own_go || fwd_done;
			if (reg_re) begin
				cyc_rdata <= rd_val;
			end else if (fwd_done) begin
				cyc_rdata <= fwd_rdata;
			end else if (own_go) begin
				cyc_rdata <= 8'h00;
			end
		end
	end
endmodule
`default_nettype wire

//--- verilog/lpib_pkg.sv
`default_nettype none
package lpib_pkg;
	// Own I/O window, LPC I/O addresses
	localparam logic [15:0] WIN_LO = 16'h0c80;
	localparam logic [15:0] WIN_HI = 16'h0ccf;
	// Companion super I/O ranges, never forwarded
	localparam logic [15:0] SIO_IDX_LO = 16'h002e;
	localparam logic [15:0] SIO_IDX_HI = 16'h002f;
	localparam logic [15:0] SIO_RT_LO = 16'h0c00;
	localparam logic [15:0] SIO_RT_HI = 16'h0c7f;
	// Memory forward limit, 24-bit expansion address space
	localparam logic [31:0] MEM_LIMIT = 32'h0100_0000;
	// Window parts, offsets from the window base
	localparam logic [6:0] OFF_GEN_HI = 7'h3b;
	localparam logic [6:0] OFF_TMR_BASE = 7'h3c;
	localparam logic [6:0] OFF_UART_BASE = 7'h40;
	// Register offsets
	localparam logic [6:0] OFF_TMR_CFG = 7'h03;
	localparam logic [6:0] OFF_TMR_STAT = 7'h04;
	localparam logic [6:0] OFF_EXP_CFG = 7'h09;
	localparam logic [6:0] OFF_MISC1 = 7'h10;
	localparam logic [6:0] OFF_DIO_MASK = 7'h1c;
	localparam logic [6:0] OFF_DIO_STAT = 7'h1e;
	localparam logic [6:0] OFF_DIO_CFG = 7'h20;
	localparam logic [6:0] OFF_AUX_OUT = 7'h23;
	localparam logic [6:0] OFF_AUX_STAT = 7'h26;
	localparam logic [6:0] OFF_WDT_CFG = 7'h28;
	localparam logic [6:0] OFF_AUX_CFG = 7'h2b;
	localparam logic [6:0] OFF_ENV_CFG = 7'h2d;
	localparam logic [6:0] OFF_ENV_STAT = 7'h2e;
	localparam logic [6:0] OFF_ISA_EN_LO = 7'h30;
	localparam logic [6:0] OFF_ISA_EN_HI = 7'h31;
	// Field positions
	localparam int CFG_EN = 7;
	localparam int CFG_SEL = 4;
	localparam int EXP_SEL = 6;
	localparam int EXP_EN = 3;
	localparam int EXP_STAT = 1;
	localparam int MISC1_KEEP = 1;
	localparam int ENV_TEST = 3;
	localparam int ENV_REPEAT = 7;
	// Expansion bus interrupt lines
	localparam logic [15:0] ISA_LINES = 16'hdef8;
	// Reset values
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [15:0] RST_ISA_EN = 16'h0000;
	localparam logic [3:0] RST_CFG = 4'h0;
	// Synchroniser width: plat reset, 16 ISA, 4 UART, exp, thermal, battery
	localparam int SYNC_W = 24;
endpackage
`default_nettype wire

//--- verilog/lpib_sync.sv
`default_nettype none
module lpib_sync #(
	parameter int W = 1
) (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_r;

	// Two flops; first stage feeds only the second
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			meta_r <= '0;
			q <= '0;
		end else begin
			meta_r <= d;
			q <= meta_r;
		end
	end
endmodule
`default_nettype wire

//--- verilog/lpib_fwd.sv
`default_nettype none
module lpib_fwd (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic start,
	input wire logic io,
	input wire logic wr,
	input wire logic [23:0] addr,
	input wire logic [7:0] wdata,
	output logic busy,
	output logic done,
	output logic [7:0] rdata,
	output logic isa_req,
	output logic isa_io,
	output logic isa_wr,
	output logic [23:0] isa_addr,
	output logic [7:0] isa_wdata,
	input wire logic isa_ack,
	input wire logic [7:0] isa_rdata
);
	typedef enum logic {FWD_IDLE, FWD_RUN} lpib_fwd_t;
	lpib_fwd_t st_r;

	// Wait state held while the expansion cycle runs
	assign busy = (st_r == FWD_RUN);
	assign isa_req = busy;

	// Latch cycle, wait for target acknowledge
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			st_r <= FWD_IDLE;
			isa_io <= 1'b0;
			isa_wr <= 1'b0;
			isa_addr <= '0;
			isa_wdata <= '0;
			rdata <= '0;
			done <= 1'b0;
		end else begin
			done <= 1'b0;
			unique case (st_r)
				FWD_IDLE: begin
					if (start) begin
						st_r <= FWD_RUN;
						isa_io <= io;
						isa_wr <= wr;
						isa_addr <= addr;
						isa_wdata <= wdata;
					end
				end
				FWD_RUN: begin
					if (isa_ack) begin
						st_r <= FWD_IDLE;
						rdata <= isa_wr ? 8'h00 : isa_rdata;
						done <= 1'b1;
					end
				end
			endcase
		end
	end
endmodule
`default_nettype wire

//--- test/lpib_isa_target.sv
`default_nettype none
module lpib_isa_target (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic isa_req,
	input wire logic [23:0] isa_addr,
	input wire logic [3:0] isa_dly,
	output logic isa_ack,
	output logic [7:0] isa_rdata
);
	logic [3:0] cnt_r;
	// Ack after isa_dly wait cycles; data toggles when not acking
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			cnt_r <= 4'h0;
			isa_ack <= 1'b0;
			isa_rdata <= 8'h00;
		end else if (isa_req && !isa_ack && cnt_r >= isa_dly) begin
			isa_ack <= 1'b1;
			isa_rdata <= isa_addr[7:0] ^ 8'h5a;
		end else begin
			cnt_r <= (isa_req && !isa_ack) ? cnt_r + 4'h1 : 4'h0;
			isa_ack <= 1'b0;
			isa_rdata <= ~isa_rdata;
		end
	end
endmodule
`default_nettype wire

//--- test/lpib_monitor.sv
`default_nettype none
module lpib_monitor (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic cyc_req,
	input wire logic cyc_io,
	input wire logic cyc_wr,
	input wire logic [31:0] cyc_addr,
	input wire logic [7:0] cyc_wdata,
	input wire logic cyc_claim,
	input wire logic cyc_wait,
	input wire logic cyc_done,
	input wire logic [7:0] cyc_rdata,
	input wire logic isa_req,
	input wire logic isa_io,
	input wire logic isa_wr,
	input wire logic [23:0] isa_addr,
	input wire logic [7:0] isa_wdata,
	input wire logic isa_ack,
	input wire logic [7:0] isa_rdata,
	input wire logic tmr_we,
	input wire logic tmr_re,
	input wire logic [7:0] tmr_wdata,
	input wire logic [1:0] tmr_addr,
	input wire logic [15:0] irq_active,
	input wire logic [15:0] irq_level
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	// Address classes of a request
	wire logic [15:0] a16 = cyc_addr[15:0];
	wire logic [23:0] a24 = cyc_addr[23:0];
	wire logic own = cyc_io && a16 >= lpib_pkg::WIN_LO && a16 <= lpib_pkg::WIN_HI;
	wire logic sio = cyc_io && (a16 inside {[lpib_pkg::SIO_IDX_LO:lpib_pkg::SIO_IDX_HI],
		[lpib_pkg::SIO_RT_LO:lpib_pkg::SIO_RT_HI]});
	wire logic hi_mem = !cyc_io && cyc_addr >= lpib_pkg::MEM_LIMIT;
	wire logic tmr = own && a16[15:2] == 14'h032f;
	// Phases of a forwarded cycle
	sequence fwd_run;
		isa_req && cyc_wait;
	endsequence
	sequence fwd_answer;
		cyc_done && !cyc_wait && !isa_req;
	endsequence
	own_claim_a: assert property (cyc_req && own |-> cyc_claim ##1 cyc_done)
		else $error("own cycle not answered");
	mem_ignore_a: assert property (cyc_req && hi_mem |-> !cyc_claim)
		else $error("high memory cycle claimed");
	sio_skip_a: assert property (cyc_req && sio |-> !cyc_claim)
		else $error("companion range claimed");
	fwd_take_a: assert property (cyc_req && !cyc_wait && !own && !sio && !hi_mem |->
		cyc_claim ##1 fwd_run ##0 isa_addr == $past(a24) && isa_io == $past(cyc_io)
		&& isa_wr == $past(cyc_wr) && isa_wdata == $past(cyc_wdata))
		else $error("forward not started");
	fwd_hold_a: assert property (isa_req && !isa_ack |=> fwd_run ##0 $stable(isa_addr))
		else $error("forward dropped early");
	fwd_done_a: assert property (isa_req && isa_ack |=> !cyc_wait && !cyc_done ##1
		fwd_answer ##0 cyc_rdata == ($past(isa_wr, 2) ? 8'h00 : $past(isa_rdata, 2)))
		else $error("bad answer");
	tmr_sel_a: assert property (cyc_req && tmr |-> tmr_we == cyc_wr && tmr_re == !cyc_wr
		&& tmr_addr == a16[1:0] && tmr_wdata == cyc_wdata) else $error("timer byte not selected");
	slot_idle_a: assert property ((irq_level & ~irq_active) == 16'h0000)
		else $error("level on inactive slot");
endmodule
bind lpib_top lpib_monitor lpib_monitor_inst (.clk_sys, .rstn, .cyc_req, .cyc_io, .cyc_wr,
	.cyc_addr, .cyc_wdata, .cyc_claim, .cyc_wait, .cyc_done, .cyc_rdata, .isa_req, .isa_io,
	.isa_wr, .isa_addr, .isa_wdata, .isa_ack, .isa_rdata, .tmr_we, .tmr_re, .tmr_wdata,
	.tmr_addr, .irq_active, .irq_level);
`default_nettype wire

//--- test/lpib_top_bench.sv
`default_nettype none
module lpib_top_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys = 0, rstn = 0, plat_rst_n = 1, cyc_req = 0, cyc_io = 0, cyc_wr = 0;
	logic cyc_claim, cyc_wait, cyc_done, isa_req, isa_io, isa_wr, isa_ack, tmr_we, tmr_re;
	logic [31:0] cyc_addr = 0;
	logic [7:0] cyc_wdata = 0, tmr_rdata = 0, cyc_rdata, isa_rdata, isa_wdata, tmr_wdata, rd;
	logic [7:0] aux_gpio_out;
	logic [23:0] isa_addr;
	logic [1:0] tmr_addr;
	logic [2:0] tmr_evt = 0;
	logic dio_evt = 0, aux_evt = 0, wdt_evt = 0, exp_irq_pin = 0, therm_pin = 0, batt_low_pin = 0;
	logic [15:0] isa_irq_pin = 0, irq_active, irq_level;
	logic [3:0] uart_irq_pin = 0, isa_dly = 0;
	int n_mismatch = 0, comparisons = 0;
	lpib_top lpib_top_inst (.clk_sys, .rstn, .plat_rst_n, .cyc_req, .cyc_io, .cyc_wr, .cyc_addr,
		.cyc_wdata, .cyc_claim, .cyc_wait, .cyc_done, .cyc_rdata, .isa_req, .isa_io, .isa_wr,
		.isa_addr, .isa_wdata, .isa_ack, .isa_rdata, .tmr_we, .tmr_re, .tmr_addr, .tmr_wdata,
		.tmr_rdata, .tmr_evt, .dio_evt, .aux_evt, .wdt_evt, .isa_irq_pin, .uart_irq_pin,
		.exp_irq_pin, .therm_pin, .batt_low_pin, .irq_active, .irq_level, .aux_gpio_out);
	lpib_isa_target lpib_isa_target_inst (.clk_sys, .rstn, .isa_req, .isa_addr, .isa_dly,
		.isa_ack, .isa_rdata);
	initial forever #4 clk_sys = ~clk_sys;
	task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	function automatic logic [7:0] isa_val(logic [31:0] a);
		return a[7:0] ^ 8'h5a;
	endfunction
	function automatic int irq_of(logic [2:0] s);
		return s < 5 ? s + 3 : s + 4;
	endfunction
	task automatic cyc(int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	// One request; waits, bounded, for the answer when one is due
	task automatic acc(logic io, logic w, logic [31:0] a, logic [7:0] d, logic cl);
		int k;
		@(posedge clk_sys);
		cyc_req <= 1'b1;
		cyc_io <= io;
		cyc_wr <= w;
		cyc_addr <= a;
		cyc_wdata <= d;
		#1 chk("claim", cyc_claim, cl);
		@(posedge clk_sys);
		cyc_req <= 1'b0;
		#1 k = 0;
		while (cl && cyc_done !== 1'b1 && k < 40) begin
			@(posedge clk_sys);
			#1 k = k + 1;
		end
		if (k == 40) begin
			chk("timeout", 0, 1);
			stop_test();
		end
		rd = cyc_rdata;
		chk("done", cyc_done, cl);
	endtask
	task automatic wr(logic [6:0] o, logic [7:0] d);
		acc(1'b1, 1'b1, 32'h0c80 + o, d, 1'b1);
	endtask
	task automatic rr(logic [6:0] o);
		acc(1'b1, 1'b0, 32'h0c80 + o, 8'h00, 1'b1);
	endtask
	task automatic plat();
		@(posedge clk_sys);
		plat_rst_n <= 1'b0;
		cyc(4);
		@(posedge clk_sys);
		plat_rst_n <= 1'b1;
		cyc(4);
	endtask
	initial begin
		logic [7:0] v;
		logic [31:0] a;
		logic io, w;
		static logic [33:0] ct [6] = '{{2'b10, 32'h2e}, {2'b10, 32'hc7f}, {2'b11, 32'hcd0},
			{2'b11, 32'h2d}, {2'b00, 32'h0100_0000}, {2'b01, 32'h00ff_ffff}};
		void'($urandom(32'habbf));
		cyc(4);
		rstn <= 1'b1;
		cyc(4);
		rr(7'h30);
		chk("isa_en_lo", rd, 0);
		rr(7'h06);
		chk("unused", rd, 0);
		wr(7'h30, 8'hff);
		wr(7'h31, 8'hff);
		rr(7'h31);
		chk("isa_en_hi", rd, lpib_pkg::ISA_LINES[15:8]);
		// Expansion interrupts pass through unlatched
		@(posedge clk_sys);
		isa_irq_pin <= 16'($urandom);
		cyc(5);
		chk("isa_pass", irq_level, isa_irq_pin & lpib_pkg::ISA_LINES);
		chk("slot_act", irq_active, lpib_pkg::ISA_LINES);
		@(posedge clk_sys);
		isa_irq_pin <= 16'h0000;
		cyc(5);
		chk("isa_drop", irq_level, 0);
		// Timer events on every level code
		for (int i = 0; i < 8; i++) begin
			wr(7'h03, {1'b1, i[2:0], 4'h7});
			v = 8'($urandom_range(7, 1));
			@(posedge clk_sys);
			tmr_evt <= v[2:0];
			@(posedge clk_sys);
			tmr_evt <= 3'h0;
			cyc(6);
			rr(7'h04);
			chk("tmr_stat", rd, v);
			chk("tmr_lvl", irq_level[irq_of(i[2:0])], 1);
			wr(7'h04, v);
			rr(7'h04);
			chk("tmr_clr", rd, 0);
		end
		// Watchdog and serial I/O share IRQ5
		wr(7'h28, 8'ha0);
		wr(7'h20, 8'ha0);
		wr(7'h1c, 8'h01);
		@(posedge clk_sys);
		wdt_evt <= 1'b1;
		dio_evt <= 1'b1;
		@(posedge clk_sys);
		wdt_evt <= 1'b0;
		dio_evt <= 1'b0;
		wr(7'h1e, 8'h01);
		cyc(3);
		chk("shared", irq_level[5], 1);
		wr(7'h28, 8'ha1);
		cyc(3);
		chk("shared_clr", irq_level[5], 0);
		// Boundary addresses: claimed or ignored
		foreach (ct[i]) begin
			acc(ct[i][33], 1'b0, ct[i][31:0], 8'h00, ct[i][32]);
			if (ct[i][32])
				chk("edge_rd", rd, isa_val(ct[i][31:0]));
		end
		repeat (20) begin
			io = 1'($urandom);
			a = io ? 32'($urandom_range(16'h0bff, 16'h0030)) : {8'h00, 24'($urandom)};
			w = 1'($urandom);
			isa_dly <= 4'($urandom_range(6, 0));
			acc(io, w, a, 8'($urandom), 1'b1);
			chk("fwd_rd", rd, w ? 8'h00 : isa_val(a));
		end
		for (int i = 0; i < 4; i++) begin
			tmr_rdata <= 8'($urandom);
			wr(7'h3c + 7'(i), 8'($urandom));
			rr(7'h3c + 7'(i));
			chk("tmr_rd", rd, tmr_rdata);
		end
		// Sleep-aware reset with and without the keep bit
		v = 8'($urandom);
		wr(7'h23, v);
		plat();
		rr(7'h23);
		chk("aux_plat", rd, 0);
		wr(7'h10, 8'h02);
		wr(7'h23, v);
		plat();
		rr(7'h23);
		chk("aux_keep", rd, v);
		chk("aux_pin", aux_gpio_out, v);
		rr(7'h10);
		chk("keep_por", rd, 8'h02);
		rr(7'h03);
		chk("plat_clr", rd, 0);
		@(posedge clk_sys);
		therm_pin <= 1'b1;
		cyc(5);
		rr(7'h2e);
		chk("therm", rd & 8'h01, 1);
		// Repeat flag clears on read; thermal status stays
		@(posedge clk_sys);
		therm_pin <= 1'b0;
		cyc(4);
		rr(7'h2e);
		chk("rep_set", rd[7], 1);
		rr(7'h2e);
		chk("rep_clr", rd[7], 0);
		chk("therm_stick", rd[0], 1);
		// UART on IRQ7, expansion on IRQ10, aux GPIO on IRQ4
		wr(7'h41, 8'hc0);
		wr(7'h09, 8'h88);
		wr(7'h2b, 8'h90);
		@(posedge clk_sys);
		uart_irq_pin <= 4'h2;
		exp_irq_pin <= 1'b1;
		aux_evt <= 1'b1;
		@(posedge clk_sys);
		aux_evt <= 1'b0;
		cyc(5);
		chk("src_lvl", irq_level, 16'h0490);
		chk("src_act", irq_active, 16'h0490);
		rr(7'h09);
		chk("exp_stat", rd[1], 1);
		@(posedge clk_sys);
		uart_irq_pin <= 4'h0;
		exp_irq_pin <= 1'b0;
		cyc(5);
		chk("src_drop", irq_level, 16'h0010);
		rr(7'h26);
		chk("aux_stick", rd, 1);
		stop_test();
	end
endmodule
`default_nettype wire
